// File: bench/awsc_assertions.sv
// Port-level assertions for the task-file command core
`timescale 1ns/1ps
module awsc_checker
  import awsc_pkg::*;
#(
  parameter logic DRIVE_ID = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic intrq,
  input wire logic [31:0] sec_wdata,
  input wire logic sec_wvalid,
  input wire logic wr_req,
  input wire logic [27:0] wr_lba,
  input wire logic wr_no_erase,
  input wire logic wr_done,
  input wire logic wr_err,
  input wire logic sector_erased,
  input wire logic [15:0] spare_blocks,
  input wire logic nv_smart_en,
  input wire logic nv_smart_wr,
  input wire logic nv_smart_val
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Only non-write commands may complete with an interrupt unprompted
  logic cmdw;
  assign cmdw = psel && penable && pwrite && paddr == OFS_CMD
    && pwdata[7:0] != CMD_WRITE && pwdata[7:0] != CMD_WRITE_NE;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_wrreq_word: assert property (wr_req |-> sec_wvalid) else $error("no last word");
  a_wrreq_once: assert property (wr_req |=> !wr_req) else $error("request repeats");
  a_lba_hold: assert property (wr_req |=> $stable(wr_lba)) else $error("address moved");
  a_done_irq: assert property (wr_done |=> intrq) else $error("no done irq");
  a_err_irq: assert property (wr_err |=> intrq) else $error("no error irq");
  a_noerase_gate: assert property (wr_no_erase |-> sector_erased) else $error("bad skip");
  a_nv_once: assert property (nv_smart_wr |=> !nv_smart_wr) else $error("store repeats");
  a_irq_cause: assert property ($rose(intrq) |-> $past(wr_done) || $past(wr_err)
    || $past(cmdw) || $past(cmdw, 2) || $past(cmdw, 3) || $past(cmdw, 4))
    else $error("interrupt without cause");
  c_sector: cover property (wr_req);
  c_fault: cover property (wr_err);
  c_store: cover property (nv_smart_wr);
endmodule // awsc_checker

bind awsc_top awsc_checker #(.DRIVE_ID(DRIVE_ID)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .intrq, .sec_wdata, .sec_wvalid,
  .wr_req, .wr_lba, .wr_no_erase, .wr_done, .wr_err, .sector_erased, .spare_blocks,
  .nv_smart_en, .nv_smart_wr, .nv_smart_val);

// File: bench/awsc_flash_model.sv
// Behavioural flash programming side answering sector program requests
`timescale 1ns/1ps
module awsc_flash_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_req,
  input wire logic fail,
  input wire logic [3:0] lat,
  output logic wr_done,
  output logic wr_err
);
  // ------------------------------------------------------------
  // Programming delay
  // ------------------------------------------------------------
  // A latency of at least two keeps the busy phase visible at the ports
  logic [3:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      wr_done <= 1'b0;
      wr_err <= 1'b0;
    end else begin
      wr_done <= 1'b0;
      wr_err <= 1'b0;
      if (wr_req) begin
        cnt_r <= lat;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
        wr_done <= (cnt_r == 4'h1) && !fail;
        wr_err <= (cnt_r == 4'h1) && fail;
      end
    end
  end
endmodule // awsc_flash_model

// File: bench/tb_awsc_top.sv
// Self-checking bench for the task-file command core
`timescale 1ns/1ps
module tb_awsc_top;
  import awsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wr_done, wr_err, sector_erased, nv_smart_en;
  logic pready, pslverr, intrq, sec_wvalid, wr_req, wr_no_erase, nv_smart_wr, nv_smart_val;
  logic fail, err, seen_ne;
  logic [3:0] lat;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sec_wdata, rd, last_w;
  logic [27:0] wr_lba, lba, seen_lba;
  logic [15:0] spare_blocks, seed, thr;
  int fails, checks_done, cyc, words, nvw;
  logic [7:0] ftab [8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hDB, 8'hFF};
  awsc_top #(.DRIVE_ID(1'b0)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .intrq, .sec_wdata, .sec_wvalid, .wr_req, .wr_lba,
    .wr_no_erase, .wr_done, .wr_err, .sector_erased, .spare_blocks, .nv_smart_en,
    .nv_smart_wr, .nv_smart_val);
  awsc_flash_model u_flash (.pclk, .presetn, .wr_req, .fail, .lat, .wr_done, .wr_err);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic abrt(input logic [7:0] f);
    return !(f inside {[8'hD0:8'hD4], 8'hD8, 8'hD9, 8'hDA});
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Setup, then access held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Flash completion has no fixed bound, so the wait is capped
  task wait_irq();
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 3000) fails++;
  endtask
  task smart(input logic [7:0] f);
    apb(1'b1, OFS_CYLL, {24'h0, SIG_CYLL_OK});
    apb(1'b1, OFS_CYLH, {24'h0, SIG_CYLH_OK});
    apb(1'b1, OFS_FEAT, {24'h0, f});
    apb(1'b1, OFS_CMD, {24'h0, CMD_SMART});
    @(posedge pclk);
    wait_irq();
    apb(1'b0, OFS_ERR, 0);
  endtask
  task stat(input logic [15:0] sp);
    spare_blocks <= sp;
    smart(FEAT_STATUS);
    apb(1'b0, OFS_CYLL, 0);
    chk(rd[7:0], sp < thr ? SIG_CYLL_BAD : SIG_CYLL_OK);
    apb(1'b0, OFS_CYLH, 0);
    chk(rd[7:0], sp < thr ? SIG_CYLH_BAD : SIG_CYLH_OK);
  endtask
  task wr_cmd(input logic [7:0] c, input logic [7:0] n, input int nsec, input int bad);
    int w0;
    seed = lfsr(seed);
    lba = {seed[11:0], seed};
    lat <= 4'h2 + {1'b0, seed[2:0]};
    apb(1'b1, OFS_SCNT, {24'h0, n});
    apb(1'b1, OFS_SNUM, {24'h0, lba[7:0]});
    apb(1'b1, OFS_CYLL, {24'h0, lba[15:8]});
    apb(1'b1, OFS_CYLH, {24'h0, lba[23:16]});
    apb(1'b1, OFS_DH, {24'h0, 4'hE, lba[27:24]});
    apb(1'b1, OFS_CMD, {24'h0, c});
    for (int s = 0; s < nsec; s++) begin
      repeat (2) @(posedge pclk);
      chk(intrq, s > 0);
      apb(1'b0, OFS_STAT, 0);
      chk(rd[7:0] & 8'h88, 8'h08);
      w0 = words;
      fail <= (s == bad);
      for (int i = 0; i < 128; i++) begin
        seed = lfsr(seed);
        apb(1'b1, OFS_DATA, {seed, ~seed});
      end
      wait_irq();
      chk(words - w0, 128);
      chk(last_w, {seed, ~seed});
      chk(seen_lba, 28'(lba + s));
      chk(seen_ne, c == CMD_WRITE_NE && sector_erased);
      if (s == bad) break;
    end
  endtask
  // ------------------------------------------------------------
  // Clock, monitor and sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sec_wvalid === 1'b1) begin
      words <= words + 1;
      last_w <= sec_wdata;
    end
    if (wr_req === 1'b1) begin
      seen_lba <= wr_lba;
      seen_ne <= wr_no_erase;
    end
    if (nv_smart_wr === 1'b1) nvw <= nvw + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, fail, sector_erased} = '0;
    {paddr, pwdata, lat} = '0;
    nv_smart_en = 1'b1;
    spare_blocks = 16'h0100;
    seed = 16'h0056;
    thr = THR_RST;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_SMART, 0);
    chk(rd, {15'h0, 1'b1, THR_RST});
    apb(1'b1, OFS_DH, 0);
    apb(1'b0, OFS_DH, 0);
    chk(rd[7:0], DH_FIXED);
    seed = lfsr(seed);
    apb(1'b1, OFS_FEAT, {24'h0, seed[7:0]});
    apb(1'b0, OFS_FEAT, 0);
    chk(rd[7:0], seed[7:0]);
    apb(1'b0, 8'h2C, 0);
    chk(err, 1'b1);
    $display("Test registers done");
    smart(FEAT_DISABLE);
    apb(1'b0, OFS_SMART, 0);
    chk(rd[SMB_EN], 1'b0);
    chk(nv_smart_val, 1'b0);
    chk(nvw, 1);
    smart(FEAT_STATUS);
    chk(rd[ERB_ABRT], 1'b1);
    smart(FEAT_ENABLE);
    chk(rd[ERB_ABRT], 1'b0);
    chk(nvw, 2);
    for (int i = 0; i < 8; i++) begin
      smart(ftab[i]);
      chk(rd[ERB_ABRT], abrt(ftab[i]));
    end
    stat(16'h000F);
    stat(16'h0010);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      stat({11'h0, seed[4:0]});
    end
    apb(1'b1, OFS_SMART, 32'h0000_0020);
    thr = 16'h0020;
    stat(16'h001F);
    stat(16'h0020);
    apb(1'b0, OFS_STAT, 0);
    apb(1'b1, OFS_DH, 32'h0000_0010);
    apb(1'b1, OFS_CMD, {24'h0, CMD_SMART});
    repeat (4) @(posedge pclk);
    chk(intrq, 1'b0);
    $display("Test smart done");
    sector_erased <= 1'b1;
    wr_cmd(CMD_WRITE, 8'h02, 2, 9);
    apb(1'b0, OFS_STAT, 0);
    chk(rd[7:0] & 8'hE9, 8'h40);
    sector_erased <= 1'b0;
    wr_cmd(CMD_WRITE_NE, 8'h01, 1, 9);
    $display("Test write done");
    sector_erased <= 1'b1;
    wr_cmd(CMD_WRITE_NE, 8'h00, 3, 1);
    apb(1'b0, OFS_STAT, 0);
    chk(rd[7:0] & 8'hA9, 8'h21);
    apb(1'b0, OFS_ERR, 0);
    chk(rd[ERB_ABRT], 1'b1);
    apb(1'b0, OFS_SNUM, 0);
    chk(rd[7:0], lba[7:0] + 8'h01);
    apb(1'b0, OFS_SCNT, 0);
    chk(rd[7:0], 8'hFF);
    $display("Test write fault done");
    end_sim();
  end
endmodule // tb_awsc_top

// File: pkg/awsc_core_if.sv
// Signals between the command core, its address counter and its SMART decoder
`timescale 1ns/1ps
interface awsc_core_if;
  import awsc_pkg::*;
  logic [27:0] lba;
  logic [9:0] left;
  logic [27:0] lba_inc;
  logic [9:0] left_dec;
  logic last;
  logic [7:0] feature;
  logic smart_en;
  awsc_sop_t op;
  logic abort;
  modport main_mp(output lba, left, feature, smart_en, input lba_inc, left_dec, last, op, abort);
  modport ctr_mp(input lba, left, output lba_inc, left_dec, last);
  modport dec_mp(input feature, smart_en, output op, abort);
endinterface

// File: pkg/awsc_pkg.sv
// Shared constants and types for the task-file write and SMART command block
package awsc_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_FEAT = 8'h04;
  localparam logic [7:0] OFS_SCNT = 8'h08;
  localparam logic [7:0] OFS_SNUM = 8'h0C;
  localparam logic [7:0] OFS_CYLL = 8'h10;
  localparam logic [7:0] OFS_CYLH = 8'h14;
  localparam logic [7:0] OFS_DH = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_ERR = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h24;
  localparam logic [7:0] OFS_SMART = 8'h28;
  // ------------------------------------------------------------
  // Command and feature codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE = 8'h30;
  localparam logic [7:0] CMD_WRITE_NE = 8'h38;
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] FEAT_RD_DATA = 8'hD0;
  localparam logic [7:0] FEAT_RD_THR = 8'hD1;
  localparam logic [7:0] FEAT_AUTOSAVE = 8'hD2;
  localparam logic [7:0] FEAT_SAVE = 8'hD3;
  localparam logic [7:0] FEAT_OFFLINE = 8'hD4;
  localparam logic [7:0] FEAT_ENABLE = 8'hD8;
  localparam logic [7:0] FEAT_DISABLE = 8'hD9;
  localparam logic [7:0] FEAT_STATUS = 8'hDA;
  localparam logic [7:0] SIG_CYLL_OK = 8'h4F;
  localparam logic [7:0] SIG_CYLH_OK = 8'hC2;
  localparam logic [7:0] SIG_CYLL_BAD = 8'hF4;
  localparam logic [7:0] SIG_CYLH_BAD = 8'h2C;
  // ------------------------------------------------------------
  // Field positions and sizes
  // ------------------------------------------------------------
  localparam int unsigned STB_BSY = 7;
  localparam int unsigned STB_DRDY = 6;
  localparam int unsigned STB_DF = 5;
  localparam int unsigned STB_DSC = 4;
  localparam int unsigned STB_DRQ = 3;
  localparam int unsigned STB_ERR = 0;
  localparam int unsigned ERB_ABRT = 2;
  localparam int unsigned DHB_LBA = 6;
  localparam int unsigned DHB_DRV = 4;
  localparam logic [7:0] DH_FIXED = 8'hA0;
  localparam int unsigned SMB_EN = 16;
  localparam logic [9:0] SECT_MAX = 10'h100;
  localparam logic [6:0] LAST_WORD = 7'h7F;
  localparam logic [15:0] THR_RST = 16'h0010;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SOP_OTHER, SOP_ENABLE, SOP_DISABLE, SOP_STATUS} awsc_sop_t;
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_DRQ, ST_PROG} awsc_state_t;
endpackage

// File: rtl/awsc_lba_ctr.sv
// Next sector address and residual count for multi-sector writes
`timescale 1ns/1ps
module awsc_lba_ctr
  import awsc_pkg::*;
(
  awsc_core_if.ctr_mp cif
);
  assign cif.lba_inc = cif.lba + 28'h0000001;
  assign cif.left_dec = cif.left - 10'h001;
  assign cif.last = (cif.left == 10'h001);
endmodule // awsc_lba_ctr

// File: rtl/awsc_smart_dec.sv
// SMART subcommand decoder
`timescale 1ns/1ps
module awsc_smart_dec
  import awsc_pkg::*;
(
  awsc_core_if.dec_mp cif
);
  wire f_en = (cif.feature == FEAT_ENABLE);
  wire f_dis = (cif.feature == FEAT_DISABLE);
  wire f_st = (cif.feature == FEAT_STATUS);
  wire f_other = (cif.feature == FEAT_RD_DATA) || (cif.feature == FEAT_RD_THR) ||
                 (cif.feature == FEAT_AUTOSAVE) || (cif.feature == FEAT_SAVE) ||
                 (cif.feature == FEAT_OFFLINE);
  wire known = f_en || f_dis || f_st || f_other;
  // Unknown codes abort; while disabled only the enable code gets through
  assign cif.abort = !known || (!cif.smart_en && !f_en);
  assign cif.op = f_en ? SOP_ENABLE : f_dis ? SOP_DISABLE : f_st ? SOP_STATUS : SOP_OTHER;
endmodule // awsc_smart_dec

// File: rtl/awsc_top.sv
// Task-file command core: sector writes and SMART subcommands behind APB
// ------------------------------------------------------------
// Summary of operation
// - Command 30h writes 1 to 256 sectors
// - Sector count zero means 256 sectors
// - Write starts at task-file sector address
// - Accept: BSY, then DRQ with BSY clear
// - No interrupt before first data block
// - Full sector: BSY set, DRQ cleared
// - Next sector ready: DRQ, interrupt
// - Last sector: BSY until done, then interrupt
// - Error stops write, address kept there
// - Command 38h writes without implied erase
// - Unerased sector falls back to normal write
// - Features register selects SMART subcommand
// - Unsupported SMART feature aborts
// - D8h enables SMART, D9h disables it
// - SMART enable state kept nonvolatile
// - Spares below threshold: F4h / 2Ch
// - Otherwise: 4Fh / C2h
// ------------------------------------------------------------
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module awsc_top
  import awsc_pkg::*;
#(
  parameter logic DRIVE_ID = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic intrq,
  output logic [31:0] sec_wdata,
  output logic sec_wvalid,
  output logic wr_req,
  output logic [27:0] wr_lba,
  output logic wr_no_erase,
  input wire logic wr_done,
  input wire logic wr_err,
  input wire logic sector_erased,
  input wire logic [15:0] spare_blocks,
  input wire logic nv_smart_en,
  output logic nv_smart_wr,
  output logic nv_smart_val
);
  // ------------------------------------------------------------
  // Task file and state
  // ------------------------------------------------------------
  awsc_state_t st_r, st_nxt;
  logic [7:0] cmd_r, feat_r, scnt_r, snum_r, cyll_r, cylh_r, dh_r, err_r;
  logic [9:0] left_r;
  logic [6:0] word_r;
  logic [15:0] thr_r;
  logic smart_en_r, loaded_r, df_r, errst_r, no_erase_cmd_r;
  logic intrq_r, wr_req_r, wvalid_r, nv_wr_r;
  logic [31:0] wdata_r, prdata_r;
  awsc_core_if cif();

  awsc_lba_ctr u_ctr (
    .cif(cif.ctr_mp)
  );
  awsc_smart_dec u_dec (
    .cif(cif.dec_mp)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire setup = psel && !penable;
  wire acc_wr = psel && penable && pwrite;
  wire acc_rd = psel && penable && !pwrite;
  wire sel_cmd = (paddr == OFS_CMD);
  wire sel_feat = (paddr == OFS_FEAT);
  wire sel_scnt = (paddr == OFS_SCNT);
  wire sel_snum = (paddr == OFS_SNUM);
  wire sel_cyll = (paddr == OFS_CYLL);
  wire sel_cylh = (paddr == OFS_CYLH);
  wire sel_dh = (paddr == OFS_DH);
  wire sel_stat = (paddr == OFS_STAT);
  wire sel_err = (paddr == OFS_ERR);
  wire sel_data = (paddr == OFS_DATA);
  wire sel_smart = (paddr == OFS_SMART);
  wire mapped = sel_cmd || sel_feat || sel_scnt || sel_snum || sel_cyll || sel_cylh ||
                sel_dh || sel_stat || sel_err || sel_data || sel_smart;
  wire busy = (st_r == ST_EXEC) || (st_r == ST_PROG);
  wire drq = (st_r == ST_DRQ);
  // Task file is locked while a command runs so the failing address stays put
  wire tf_wr = acc_wr && (st_r == ST_IDLE);
  wire drive_hit = (dh_r[DHB_DRV] == DRIVE_ID);
  wire cmd_go = tf_wr && sel_cmd && drive_hit;
  wire is_write = (cmd_r == CMD_WRITE) || (cmd_r == CMD_WRITE_NE);
  wire is_smart = (cmd_r == CMD_SMART);
  // Signature check; a host that skips it gets an abort
  wire sig_ok = (cyll_r == SIG_CYLL_OK) && (cylh_r == SIG_CYLH_OK);
  wire smart_bad = !sig_ok || cif.abort;
  wire exceeded = (spare_blocks < thr_r);
  wire data_wr = acc_wr && sel_data && drq;
  wire sect_full = data_wr && (word_r == LAST_WORD);
  // Status byte built from the field positions
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[STB_BSY] = busy;
    status[STB_DRDY] = !busy;
    status[STB_DF] = df_r;
    status[STB_DSC] = 1'b1;
    status[STB_DRQ] = drq;
    status[STB_ERR] = errst_r;
  end
  wire [7:0] dh_view = dh_r | DH_FIXED;

  assign cif.lba = {dh_r[3:0], cylh_r, cyll_r, snum_r};
  assign cif.left = left_r;
  assign cif.feature = feat_r;
  assign cif.smart_en = smart_en_r;

  // ------------------------------------------------------------
  // Command events
  // ------------------------------------------------------------
  // One execute cycle decides every command
  wire in_exec = (st_r == ST_EXEC);
  wire smart_run = in_exec && is_smart && !smart_bad;
  wire status_run = smart_run && (cif.op == SOP_STATUS);
  wire cmd_abort = in_exec && !is_write && (!is_smart || smart_bad);
  // A sector ends good or bad only while it is being programmed
  wire in_prog = (st_r == ST_PROG);
  wire sect_ok = in_prog && wr_done && !wr_err;
  wire sect_bad = in_prog && wr_err;
  // Raise beats the clear of a status read in the same cycle
  wire irq_set = sect_ok || sect_bad || (in_exec && !is_write);
  wire irq_clr = cmd_go || (acc_rd && sel_stat);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd_go) begin
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_write) begin
          st_nxt = ST_DRQ;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_DRQ: begin
        if (sect_full) begin
          st_nxt = ST_PROG;
        end
      end
      ST_PROG: begin
        if (wr_err) begin
          st_nxt = ST_IDLE;
        end else if (wr_done) begin
          st_nxt = cif.last ? ST_IDLE : ST_DRQ;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      word_r <= 7'h00;
      left_r <= 10'h000;
      wr_req_r <= 1'b0;
      no_erase_cmd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wr_req_r <= sect_full;
      if (st_r == ST_EXEC) begin
        left_r <= (scnt_r == 8'h00) ? SECT_MAX : {2'b00, scnt_r};
        no_erase_cmd_r <= (cmd_r == CMD_WRITE_NE);
      end
      if (st_r != ST_DRQ) begin
        word_r <= 7'h00;
      end else if (data_wr) begin
        word_r <= word_r + 7'h01;
      end
      if (sect_ok) begin
        left_r <= cif.left_dec;
      end
    end
  end

  // ------------------------------------------------------------
  // Task-file registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 8'h00;
      feat_r <= 8'h00;
      scnt_r <= 8'h00;
      snum_r <= 8'h00;
      cyll_r <= 8'h00;
      cylh_r <= 8'h00;
      dh_r <= DH_FIXED;
      thr_r <= THR_RST;
    end else if (tf_wr) begin
      if (sel_cmd) cmd_r <= pwdata[7:0];
      if (sel_feat) feat_r <= pwdata[7:0];
      if (sel_scnt) scnt_r <= pwdata[7:0];
      if (sel_snum) snum_r <= pwdata[7:0];
      if (sel_cyll) cyll_r <= pwdata[7:0];
      if (sel_cylh) cylh_r <= pwdata[7:0];
      if (sel_dh) dh_r <= pwdata[7:0];
      if (sel_smart) thr_r <= pwdata[15:0];
    end else if (status_run) begin
      cyll_r <= exceeded ? SIG_CYLL_BAD : SIG_CYLL_OK;
      cylh_r <= exceeded ? SIG_CYLH_BAD : SIG_CYLH_OK;
    end else if (sect_ok) begin
      // Address advances only after a good sector, so an error leaves it on the bad one
      {dh_r[3:0], cylh_r, cyll_r, snum_r} <= cif.lba_inc;
      scnt_r <= cif.left_dec[7:0];
    end
  end

  // ------------------------------------------------------------
  // Status, error and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 8'h00;
      errst_r <= 1'b0;
      df_r <= 1'b0;
      intrq_r <= 1'b0;
    end else begin
      if (cmd_go) begin
        err_r <= 8'h00;
        errst_r <= 1'b0;
        df_r <= 1'b0;
      end else if (cmd_abort) begin
        err_r[ERB_ABRT] <= 1'b1;
        errst_r <= 1'b1;
      end else if (sect_bad) begin
        err_r[ERB_ABRT] <= 1'b1;
        errst_r <= 1'b1;
        df_r <= 1'b1;
      end
      if (irq_set) begin
        intrq_r <= 1'b1;
      end else if (irq_clr) begin
        intrq_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // SMART enable, kept in nonvolatile storage
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smart_en_r <= 1'b0;
      loaded_r <= 1'b0;
      nv_wr_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
      nv_wr_r <= 1'b0;
      if (!loaded_r) begin
        smart_en_r <= nv_smart_en;
      end else if (smart_run) begin
        if (cif.op == SOP_ENABLE) begin
          smart_en_r <= 1'b1;
          nv_wr_r <= 1'b1;
        end else if (cif.op == SOP_DISABLE) begin
          smart_en_r <= 1'b0;
          nv_wr_r <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Sector data stream to the flash path
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_r <= 32'h0000_0000;
      wvalid_r <= 1'b0;
    end else begin
      wvalid_r <= data_wr;
      if (data_wr) wdata_r <= pwdata;
    end
  end

  // ------------------------------------------------------------
  // APB read data, captured in the setup cycle
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_feat) rd_mux[7:0] = feat_r;
    if (sel_scnt) rd_mux[7:0] = scnt_r;
    if (sel_snum) rd_mux[7:0] = snum_r;
    if (sel_cyll) rd_mux[7:0] = cyll_r;
    if (sel_cylh) rd_mux[7:0] = cylh_r;
    if (sel_dh) rd_mux[7:0] = dh_view;
    if (sel_stat) rd_mux[7:0] = status;
    if (sel_err) rd_mux[7:0] = err_r;
    if (sel_smart) rd_mux = {15'h0000, smart_en_r, thr_r};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign intrq = intrq_r;
  assign sec_wdata = wdata_r;
  assign sec_wvalid = wvalid_r;
  assign wr_req = wr_req_r;
  assign wr_lba = cif.lba;
  // Falls back to an ordinary write when the target is not erased
  assign wr_no_erase = no_erase_cmd_r && sector_erased;
  assign nv_smart_wr = nv_wr_r;
  assign nv_smart_val = smart_en_r;
endmodule // awsc_top
